// ---- hw/tcu_pkg.sv ----
// constants for the 8-bit timer counter and compare unit
package tcu_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_IRQEN = 8'h10;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACT_LSB = 2;
   localparam int CTRL_CSEL_LSB = 4;
   localparam int CTRL_FORCE_BIT = 7;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PCPWM = 2'h1;
   localparam logic [1:0] MODE_CTC = 2'h2;
   localparam logic [1:0] MODE_FAST = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam logic [2:0] CSEL_NONE = 3'h0;
   localparam logic [2:0] CSEL_DIV1 = 3'h1;
   localparam logic [2:0] CSEL_DIV8 = 3'h2;
   localparam logic [2:0] CSEL_DIV64 = 3'h3;
   localparam logic [2:0] CSEL_DIV256 = 3'h4;
   localparam logic [2:0] CSEL_DIV1024 = 3'h5;
   localparam logic [2:0] CSEL_EXT_FALL = 3'h6;
   localparam logic [2:0] CSEL_EXT_RISE = 3'h7;
   localparam logic [9:0] PRESC_MASK8 = 10'h007;
   localparam logic [9:0] PRESC_MASK64 = 10'h03F;
   localparam logic [9:0] PRESC_MASK256 = 10'h0FF;
   localparam logic [9:0] PRESC_MASK1024 = 10'h3FF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] ACT_RST = 2'h0;
   localparam logic [2:0] CSEL_RST = 3'h0;
   localparam logic OC_RST = 1'b0;
endpackage

// ---- hw/tcu_timer.sv ----
// 8-bit timer counter with one compare channel behind an APB slave
// Summary of operation
// - each tick clears, increments or decrements the counter by mode and direction
// - clock source select zero gives no tick; counter stays stopped
// - software may read and write the counter at any time
// - a counter write beats any clear or count in that cycle
// - counting sequence follows the two waveform mode bits
// - overflow flag sets where the mode says and can request an interrupt
// - 8-bit comparator flags equality of counter and compare register
// - compare match flag sets on the same tick on which equality is seen
// - compare interrupt only with flag, compare enable and global enable set
// - compare flag clears when serviced or when software writes one to it
// - output follows match, mode, action field, top and bottom
// - compare register buffered in PWM modes, direct in normal and CTC
// - buffered compare value moves to active register only at top, never at bottom
// - compare address reaches buffer when buffered, else the active register
// - force strobe in non-PWM modes acts like a match without flag or clear
// - a counter write blocks a match on the next tick, even when stopped
// - action field changes act at once, not buffered
// - top indication at maximum, or at compare match in CTC; bottom indication at zero
// - bottom is 0x00, max is 0xFF, top is max or compare by mode
// - action field zero leaves output state unchanged on matches
// - reset clears the compare output state to zero
`timescale 1ns/1ps
`default_nettype none
module tcu_timer #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extTickPin,
   input wire logic globalIrqEnable,
   input wire logic compareIrqAck,
   input wire logic overflowIrqAck,
   output logic compareIrq,
   output logic overflowIrq,
   output logic compareOutputState,
   output logic pinOverride,
   output logic topInd,
   output logic bottomInd
);
   if (ADDR_W < 5) begin : g_badAddr
      $error("ADDR_W too small for register map");
   end

   // register state
   logic [1:0] modeQ, modeD;
   logic [1:0] actionQ, actionD;
   logic [2:0] cselQ, cselD;
   logic [7:0] countQ, countD;
   logic upQ, upD;
   logic [7:0] ocrQ, ocrD;
   logic [7:0] ocrBufQ, ocrBufD;
   logic ovfFlagQ, ovfFlagD;
   logic cmpFlagQ, cmpFlagD;
   logic ovfIeQ, ovfIeD;
   logic cmpIeQ, cmpIeD;
   logic blockQ, blockD;
   logic ocStateQ, ocStateD;
   logic [9:0] prescQ, prescD;
   logic extPrevQ, extPrevD;
   logic [31:0] prdataQ, prdataD;

   // bus decode
   logic access;
   logic wrAcc;
   logic [7:0] offs;
   logic hit;
   logic wrCtrl;
   logic wrCount;
   logic wrCompare;
   logic wrFlags;
   logic wrIrqen;
   logic buffered;
   logic tick;
   logic matchNow;
   logic matchHit;
   logic atMax;
   logic atBottom;
   logic forceHit;
   logic [1:0] newAction;

   assign offs = 8'(paddr);
   assign access = psel && penable;
   assign wrAcc = access && pwrite && pstrb[0];
   assign hit = (offs == tcu_pkg::ADDR_CTRL) || (offs == tcu_pkg::ADDR_COUNT) ||
                (offs == tcu_pkg::ADDR_COMPARE) || (offs == tcu_pkg::ADDR_FLAGS) ||
                (offs == tcu_pkg::ADDR_IRQEN);
   assign wrCtrl = wrAcc && (offs == tcu_pkg::ADDR_CTRL);
   assign wrCount = wrAcc && (offs == tcu_pkg::ADDR_COUNT);
   assign wrCompare = wrAcc && (offs == tcu_pkg::ADDR_COMPARE);
   assign wrFlags = wrAcc && (offs == tcu_pkg::ADDR_FLAGS);
   assign wrIrqen = wrAcc && (offs == tcu_pkg::ADDR_IRQEN);
   assign pready = 1'b1;
   assign pslverr = access && !hit;
   assign prdata = prdataQ;

   // buffering in PWM modes only
   assign buffered = (modeQ == tcu_pkg::MODE_PCPWM) || (modeQ == tcu_pkg::MODE_FAST);

   // tick source select
   always_comb begin
      unique case (cselQ)
         tcu_pkg::CSEL_NONE: tick = 1'b0;
         tcu_pkg::CSEL_DIV1: tick = 1'b1;
         tcu_pkg::CSEL_DIV8: tick = (prescQ & tcu_pkg::PRESC_MASK8) == tcu_pkg::PRESC_MASK8;
         tcu_pkg::CSEL_DIV64: tick = (prescQ & tcu_pkg::PRESC_MASK64) == tcu_pkg::PRESC_MASK64;
         tcu_pkg::CSEL_DIV256: tick = (prescQ & tcu_pkg::PRESC_MASK256) == tcu_pkg::PRESC_MASK256;
         tcu_pkg::CSEL_DIV1024: tick = prescQ == tcu_pkg::PRESC_MASK1024;
         tcu_pkg::CSEL_EXT_FALL: tick = extPrevQ && !extTickPin;
         tcu_pkg::CSEL_EXT_RISE: tick = !extPrevQ && extTickPin;
      endcase
   end

   // comparator and extreme values
   assign matchNow = countQ == ocrQ;
   assign matchHit = tick && matchNow && !blockQ;
   assign atMax = countQ == tcu_pkg::CNT_MAX;
   assign atBottom = countQ == tcu_pkg::CNT_BOTTOM;
   assign topInd = (modeQ == tcu_pkg::MODE_CTC) ? matchNow : atMax;
   assign bottomInd = atBottom;
   assign newAction = pwdata[tcu_pkg::CTRL_ACT_LSB +: 2];
   assign forceHit = wrCtrl && pwdata[tcu_pkg::CTRL_FORCE_BIT] && !buffered;

   // interrupt requests, compare output state and pin override
   assign compareIrq = cmpFlagQ && cmpIeQ && globalIrqEnable;
   assign overflowIrq = ovfFlagQ && ovfIeQ && globalIrqEnable;
   assign compareOutputState = ocStateQ;
   assign pinOverride = actionQ != tcu_pkg::ACT_NONE;

   // next state of the whole unit
   always_comb begin
      modeD = modeQ;
      actionD = actionQ;
      cselD = cselQ;
      countD = countQ;
      upD = upQ;
      ocrD = ocrQ;
      ocrBufD = ocrBufQ;
      ovfFlagD = ovfFlagQ;
      cmpFlagD = cmpFlagQ;
      ovfIeD = ovfIeQ;
      cmpIeD = cmpIeQ;
      blockD = blockQ;
      ocStateD = ocStateQ;
      prescD = prescQ + 10'h001;
      extPrevD = extTickPin;
      prdataD = prdataQ;
      // control fields, action takes effect at once
      if (wrCtrl) begin
         modeD = pwdata[tcu_pkg::CTRL_MODE_LSB +: 2];
         actionD = newAction;
         cselD = pwdata[tcu_pkg::CTRL_CSEL_LSB +: 3];
      end
      if (wrIrqen) begin
         ovfIeD = pwdata[tcu_pkg::FLAG_OVF_BIT];
         cmpIeD = pwdata[tcu_pkg::FLAG_CMP_BIT];
      end
      // counting sequence per mode
      if (tick) begin
         unique case (modeQ)
            tcu_pkg::MODE_NORMAL: begin
               countD = countQ + 8'h01;
               upD = 1'b1;
               if (atMax) begin
                  ovfFlagD = 1'b1;
               end
            end
            tcu_pkg::MODE_CTC: begin
               upD = 1'b1;
               if (matchHit) begin
                  countD = tcu_pkg::CNT_BOTTOM;
               end else begin
                  countD = countQ + 8'h01;
               end
               if (atMax && !matchHit) begin
                  ovfFlagD = 1'b1;
               end
            end
            tcu_pkg::MODE_FAST: begin
               countD = countQ + 8'h01;
               upD = 1'b1;
               if (atMax) begin
                  ovfFlagD = 1'b1;
                  ocrD = ocrBufQ;
               end
            end
            tcu_pkg::MODE_PCPWM: begin
               if (upQ && atMax) begin
                  upD = 1'b0;
                  countD = countQ - 8'h01;
                  ocrD = ocrBufQ;
               end else if (!upQ && atBottom) begin
                  upD = 1'b1;
                  countD = countQ + 8'h01;
                  ovfFlagD = 1'b1;
               end else if (upQ) begin
                  countD = countQ + 8'h01;
               end else begin
                  countD = countQ - 8'h01;
               end
            end
         endcase
      end
      // counter write wins and blocks the next match
      if (wrCount) begin
         countD = pwdata[7:0];
         blockD = 1'b1;
      end else if (tick) begin
         blockD = 1'b0;
      end
      // compare register access
      if (wrCompare) begin
         ocrBufD = pwdata[7:0];
         if (!buffered) begin
            ocrD = pwdata[7:0];
         end
      end
      // compare output state
      if (matchHit && (actionQ != tcu_pkg::ACT_NONE)) begin
         unique case (modeQ)
            tcu_pkg::MODE_NORMAL, tcu_pkg::MODE_CTC: begin
               if (actionQ == tcu_pkg::ACT_TOGGLE) begin
                  ocStateD = !ocStateQ;
               end else begin
                  ocStateD = actionQ == tcu_pkg::ACT_SET;
               end
            end
            tcu_pkg::MODE_FAST: begin
               if (actionQ != tcu_pkg::ACT_TOGGLE) begin
                  ocStateD = actionQ == tcu_pkg::ACT_SET;
               end
            end
            tcu_pkg::MODE_PCPWM: begin
               if (actionQ != tcu_pkg::ACT_TOGGLE) begin
                  ocStateD = (actionQ == tcu_pkg::ACT_SET) ~^ upQ;
               end
            end
         endcase
      end
      // fast PWM restores level at bottom
      if (tick && atMax && (modeQ == tcu_pkg::MODE_FAST)) begin
         if (actionQ == tcu_pkg::ACT_CLEAR) begin
            ocStateD = 1'b1;
         end else if (actionQ == tcu_pkg::ACT_SET) begin
            ocStateD = 1'b0;
         end
      end
      // forced compare in non-PWM modes
      if (forceHit && (newAction != tcu_pkg::ACT_NONE)) begin
         if (newAction == tcu_pkg::ACT_TOGGLE) begin
            ocStateD = !ocStateQ;
         end else begin
            ocStateD = newAction == tcu_pkg::ACT_SET;
         end
      end
      // flags: clear first, a set in the same cycle wins
      if ((wrFlags && pwdata[tcu_pkg::FLAG_CMP_BIT]) || compareIrqAck) begin
         cmpFlagD = 1'b0;
      end
      if (matchHit) begin
         cmpFlagD = 1'b1;
      end
      if ((wrFlags && pwdata[tcu_pkg::FLAG_OVF_BIT]) || overflowIrqAck) begin
         ovfFlagD = 1'b0;
      end
      // read data captured in setup phase
      if (psel && !penable) begin
         prdataD = 32'h0000_0000;
         unique case (offs)
            tcu_pkg::ADDR_CTRL: begin
               prdataD[tcu_pkg::CTRL_MODE_LSB +: 2] = modeQ;
               prdataD[tcu_pkg::CTRL_ACT_LSB +: 2] = actionQ;
               prdataD[tcu_pkg::CTRL_CSEL_LSB +: 3] = cselQ;
            end
            tcu_pkg::ADDR_COUNT: prdataD[7:0] = countQ;
            tcu_pkg::ADDR_COMPARE: prdataD[7:0] = buffered ? ocrBufQ : ocrQ;
            tcu_pkg::ADDR_FLAGS: begin
               prdataD[tcu_pkg::FLAG_OVF_BIT] = ovfFlagQ;
               prdataD[tcu_pkg::FLAG_CMP_BIT] = cmpFlagQ;
            end
            tcu_pkg::ADDR_IRQEN: begin
               prdataD[tcu_pkg::FLAG_OVF_BIT] = ovfIeQ;
               prdataD[tcu_pkg::FLAG_CMP_BIT] = cmpIeQ;
            end
            default: prdataD = 32'h0000_0000;
         endcase
      end
   end

   // overflow set must survive a same-cycle clear
   logic ovfSet;
   assign ovfSet = tick && !wrCount && (
      ((modeQ == tcu_pkg::MODE_NORMAL) && atMax) ||
      ((modeQ == tcu_pkg::MODE_CTC) && atMax && !matchHit) ||
      ((modeQ == tcu_pkg::MODE_FAST) && atMax) ||
      ((modeQ == tcu_pkg::MODE_PCPWM) && !upQ && atBottom));

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         modeQ <= tcu_pkg::MODE_RST;
         actionQ <= tcu_pkg::ACT_RST;
         cselQ <= tcu_pkg::CSEL_RST;
         countQ <= tcu_pkg::COUNT_RST;
         upQ <= 1'b1;
         ocrQ <= tcu_pkg::COMPARE_RST;
         ocrBufQ <= tcu_pkg::COMPARE_RST;
         ovfFlagQ <= 1'b0;
         cmpFlagQ <= 1'b0;
         ovfIeQ <= 1'b0;
         cmpIeQ <= 1'b0;
         blockQ <= 1'b0;
         ocStateQ <= tcu_pkg::OC_RST;
         prescQ <= 10'h000;
         extPrevQ <= 1'b0;
         prdataQ <= 32'h0000_0000;
      end else begin
         modeQ <= modeD;
         actionQ <= actionD;
         cselQ <= cselD;
         countQ <= countD;
         upQ <= upD;
         ocrQ <= ocrD;
         ocrBufQ <= ocrBufD;
         ovfFlagQ <= ovfFlagD || ovfSet;
         cmpFlagQ <= cmpFlagD;
         ovfIeQ <= ovfIeD;
         cmpIeQ <= cmpIeD;
         blockQ <= blockD;
         ocStateQ <= ocStateD;
         prescQ <= prescD;
         extPrevQ <= extPrevD;
         prdataQ <= prdataD;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_blockedTick;
      blockQ && tick && !cmpFlagQ && !wrCount;
   endsequence

   sequence s_setupRead;
      psel && !penable && !pwrite && (offs == tcu_pkg::ADDR_COUNT);
   endsequence

   property p_stopped;
      (cselQ == tcu_pkg::CSEL_NONE) && !wrCount |=> $stable(countQ);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

   property p_wrPrio;
      wrCount |=> countQ == $past(pwdata[7:0]);
   endproperty
   a_wrPrio: assert property (p_wrPrio) else $error("counter write lost");

   property p_matchFlag;
      tick && (countQ == ocrQ) && !blockQ |=> cmpFlagQ;
   endproperty
   a_matchFlag: assert property (p_matchFlag) else $error("match flag not set");

   property p_block;
      s_blockedTick |=> !cmpFlagQ;
   endproperty
   a_block: assert property (p_block) else $error("blocked match set flag");

   property p_irq;
      compareIrq |-> cmpFlagQ && cmpIeQ && globalIrqEnable;
   endproperty
   a_irq: assert property (p_irq) else $error("compare irq without cause");

   property p_ack;
      compareIrqAck && !matchHit |=> !cmpFlagQ;
   endproperty
   a_ack: assert property (p_ack) else $error("flag survived service");

   property p_bufLoad;
      buffered && !wrCompare && !(tick && atMax) && (modeQ == $past(modeQ)) |=> $stable(ocrQ);
   endproperty
   a_bufLoad: assert property (p_bufLoad) else $error("compare loaded off top");

   property p_wrap;
      tick && !wrCount && atMax && (modeQ == tcu_pkg::MODE_NORMAL)
         |=> (countQ == tcu_pkg::CNT_BOTTOM) && ovfFlagQ;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at max");

   property p_actNone;
      (actionQ == tcu_pkg::ACT_NONE) && !wrCtrl |=> $stable(ocStateQ);
   endproperty
   a_actNone: assert property (p_actNone) else $error("output moved with no action");

   property p_force;
      forceHit && (newAction == tcu_pkg::ACT_TOGGLE) && !matchHit && !cmpFlagQ
         |=> (ocStateQ != $past(ocStateQ)) && !cmpFlagQ;
   endproperty
   a_force: assert property (p_force) else $error("force strobe misbehaved");

   property p_read;
      s_setupRead ##1 access |-> prdata[7:0] == $past(countQ);
   endproperty
   a_read: assert property (p_read) else $error("counter read wrong");

   property p_rst;
      @(posedge clk) disable iff (1'b0) rst |=> !ocStateQ;
   endproperty
   a_rst: assert property (p_rst) else $error("output state not cleared");
endmodule
`default_nettype wire

// ---- testbench/tcu_timer_test.sv ----
// self-checking testbench for the 8-bit timer counter and compare unit
`timescale 1ns/1ps
`default_nettype none
module tcu_timer_test;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} tcu_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic extTickPin = 1'b0, globalIrqEnable = 1'b0, compareIrqAck = 1'b0, overflowIrqAck = 1'b0;
   logic compareIrq, overflowIrq, compareOutputState, pinOverride, topInd, bottomInd;
   int failures = 0;
   int compares = 0;
   logic [31:0] got;
   logic err;
   int n;
   tcu_row_s rows[6];
   tcu_timer dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extTickPin(extTickPin), .globalIrqEnable(globalIrqEnable),
      .compareIrqAck(compareIrqAck), .overflowIrqAck(overflowIrqAck),
      .compareIrq(compareIrq), .overflowIrq(overflowIrq),
      .compareOutputState(compareOutputState), .pinOverride(pinOverride),
      .topInd(topInd), .bottomInd(bottomInd));
   always #50 clk = ~clk;
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] g, input logic [31:0] e, input string msg);
      compares++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, g, e);
      end
   endtask
   task automatic hang(input int k, input string msg);
      if (k >= 40) begin
         failures++;
         $display("Error at %0t: timeout waiting for %s", $time, msg);
         give_verdict();
      end
   endtask
   // one APB transfer, setup then access until pready, then one idle cycle
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      got = prdata;
      err = pslverr;
      hang(k, "pready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(got & m, e, "register read");
   endtask
   // one high pulse on the external tick pin
   task automatic pulse();
      extTickPin <= 1'b1;
      @(posedge clk);
      extTickPin <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      rows[0] = '{tcu_pkg::ADDR_COUNT, 32'h5A, 32'h5A, 1'b0};
      rows[1] = '{tcu_pkg::ADDR_COMPARE, 32'h33, 32'h33, 1'b0};
      rows[2] = '{tcu_pkg::ADDR_IRQEN, 32'h3, 32'h3, 1'b0};
      rows[3] = '{tcu_pkg::ADDR_CTRL, 32'h02, 32'h02, 1'b0};
      rows[4] = '{8'h14, 32'hFF, 32'h0, 1'b1};
      rows[5] = '{tcu_pkg::ADDR_CTRL, 32'h80, 32'h00, 1'b0};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({31'h0, compareOutputState}, 32'h0, "reset output state");
      check({30'h0, bottomInd, topInd}, 32'h2, "reset indications");
      check({30'h0, compareIrq, overflowIrq}, 32'h0, "reset irqs");
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         check({31'h0, err}, {31'h0, rows[i].e}, "write error response");
         rdchk(rows[i].a, 32'hFFFFFFFF, rows[i].r);
         check({31'h0, err}, {31'h0, rows[i].e}, "read error response");
      end
      $display("test register rows done");
      rdchk(tcu_pkg::ADDR_COUNT, 32'hFF, 32'h5A);
      wr(tcu_pkg::ADDR_CTRL, 32'h8C);
      check({30'h0, pinOverride, compareOutputState}, 32'h3, "forced set");
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h2, 32'h0);
      rdchk(tcu_pkg::ADDR_COUNT, 32'hFF, 32'h5A);
      wr(tcu_pkg::ADDR_CTRL, 32'h03);
      check({30'h0, pinOverride, compareOutputState}, 32'h1, "mode change");
      wr(tcu_pkg::ADDR_CTRL, 32'h04);
      wr(tcu_pkg::ADDR_CTRL, 32'h84);
      check({31'h0, compareOutputState}, 32'h0, "forced toggle");
      $display("test force done");
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      wr(tcu_pkg::ADDR_COUNT, 32'hFD);
      wr(tcu_pkg::ADDR_FLAGS, 32'h3);
      globalIrqEnable <= 1'b1;
      wr(tcu_pkg::ADDR_CTRL, 32'h10);
      for (n = 0; n < 40 && topInd !== 1'b1; n++) @(posedge clk);
      hang(n, "top");
      for (n = 0; n < 40 && bottomInd !== 1'b1; n++) @(posedge clk);
      hang(n, "bottom");
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h1, 32'h1);
      check({31'h0, overflowIrq}, 32'h1, "overflow irq");
      overflowIrqAck <= 1'b1;
      @(posedge clk);
      overflowIrqAck <= 1'b0;
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h1, 32'h0);
      $display("test overflow done");
      wr(tcu_pkg::ADDR_COMPARE, 32'h10);
      wr(tcu_pkg::ADDR_COUNT, 32'h0E);
      wr(tcu_pkg::ADDR_IRQEN, 32'h2);
      wr(tcu_pkg::ADDR_CTRL, 32'h10);
      for (n = 0; n < 40 && compareIrq !== 1'b1; n++) @(posedge clk);
      hang(n, "compare irq");
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h2, 32'h2);
      globalIrqEnable <= 1'b0;
      repeat (2) @(posedge clk);
      check({31'h0, compareIrq}, 32'h0, "global mask");
      globalIrqEnable <= 1'b1;
      compareIrqAck <= 1'b1;
      @(posedge clk);
      compareIrqAck <= 1'b0;
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h2, 32'h0);
      check({31'h0, compareIrq}, 32'h0, "irq after ack");
      $display("test compare done");
      wr(tcu_pkg::ADDR_COMPARE, 32'h20);
      wr(tcu_pkg::ADDR_COUNT, 32'h20);
      wr(tcu_pkg::ADDR_FLAGS, 32'h3);
      wr(tcu_pkg::ADDR_CTRL, 32'h10);
      repeat (4) @(posedge clk);
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h2, 32'h0);
      $display("test write block done");
      wr(tcu_pkg::ADDR_CTRL, 32'h10);
      wr(tcu_pkg::ADDR_COUNT, 32'h80);
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      apb(1'b0, tcu_pkg::ADDR_COUNT, 32'h0);
      check({31'h0, got[7:0] >= 8'h80 && got[7:0] <= 8'h84}, 32'h1, "write priority");
      $display("test write priority done");
      wr(tcu_pkg::ADDR_COMPARE, 32'h05);
      wr(tcu_pkg::ADDR_COUNT, 32'h00);
      wr(tcu_pkg::ADDR_CTRL, 32'h16);
      repeat (20) @(posedge clk);
      wr(tcu_pkg::ADDR_CTRL, 32'h06);
      apb(1'b0, tcu_pkg::ADDR_COUNT, 32'h0);
      check({31'h0, got[7:0] <= 8'h05}, 32'h1, "ctc range");
      wr(tcu_pkg::ADDR_COUNT, 32'h05);
      check({31'h0, topInd}, 32'h1, "ctc top");
      $display("test ctc done");
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      wr(tcu_pkg::ADDR_COMPARE, 32'h10);
      wr(tcu_pkg::ADDR_CTRL, 32'h03);
      wr(tcu_pkg::ADDR_COMPARE, 32'h40);
      rdchk(tcu_pkg::ADDR_COMPARE, 32'hFF, 32'h40);
      wr(tcu_pkg::ADDR_COUNT, 32'h0E);
      wr(tcu_pkg::ADDR_FLAGS, 32'h3);
      wr(tcu_pkg::ADDR_CTRL, 32'h13);
      repeat (6) @(posedge clk);
      wr(tcu_pkg::ADDR_CTRL, 32'h03);
      rdchk(tcu_pkg::ADDR_FLAGS, 32'h2, 32'h2);
      $display("test buffering done");
      wr(tcu_pkg::ADDR_CTRL, 32'h00);
      wr(tcu_pkg::ADDR_COUNT, 32'h00);
      wr(tcu_pkg::ADDR_CTRL, 32'h70);
      repeat (3) pulse();
      rdchk(tcu_pkg::ADDR_COUNT, 32'hFF, 32'h03);
      wr(tcu_pkg::ADDR_CTRL, 32'h60);
      pulse();
      rdchk(tcu_pkg::ADDR_COUNT, 32'hFF, 32'h04);
      wr(tcu_pkg::ADDR_COUNT, 32'hFE);
      wr(tcu_pkg::ADDR_CTRL, 32'h71);
      repeat (3) pulse();
      rdchk(tcu_pkg::ADDR_COUNT, 32'hFF, 32'hFD);
      $display("test external tick done");
      give_verdict();
   end
endmodule
`default_nettype wire
